// file: rtl/rsc_pkg.sv
// package for the reconfiguration schedule control block
// assumes a single message clock; message fields arrive as parsed ascii characters
package rsc_pkg;
    localparam int NAME_CHARS    = 16;
    localparam int TIME_CHARS    = 8;
    localparam int FRAME_CHARS   = 6;
    localparam int CAUSE_CHARS   = 4;
    localparam int HOUR_MAX      = 23;
    localparam int MINSEC_MAX    = 59;
    localparam int UPPER_MAX     = 19;
    localparam int LOWER_MAX     = 249;
    localparam logic [7:0] CHAR_COLON = 8'h3A;
    localparam logic [7:0] CHAR_ZERO  = 8'h30;
    localparam logic [7:0] CHAR_NINE  = 8'h39;
    localparam logic       PENDING_RESET = 1'b0;

    // request kinds from upstream
    typedef enum logic [1:0] {
        RSC_REQ_CHANGE = 2'h0,
        RSC_REQ_QUERY  = 2'h1,
        RSC_REQ_CANCEL = 2'h2
    } rsc_req_type;

    // answer kinds to upstream
    typedef enum logic [1:0] {
        RSC_MSG_CONFIRM  = 2'h0,
        RSC_MSG_WITHDRAW = 2'h1,
        RSC_MSG_REJECT   = 2'h2
    } rsc_msg_type;

    // four character cause codes
    localparam logic [31:0] NAME_UNKNOWN_CODE      = 32'h4E414D45;
    localparam logic [31:0] BAD_INSTANT_CODE       = 32'h494E5354;
    localparam logic [31:0] ALREADY_WAITING_CODE   = 32'h50454E44;
    localparam logic [31:0] MISSING_RESOURCE_CODE  = 32'h4E524553;
    localparam logic [31:0] NOTHING_WAITING_CODE   = 32'h4E4F4E45;
    localparam logic [31:0] TOO_LATE_CODE          = 32'h4C415445;

    typedef struct packed {
        logic [NAME_CHARS*8-1:0]  name;
        logic [TIME_CHARS*8-1:0]  utc;
        logic [FRAME_CHARS*8-1:0] frame_count_field;
    } rsc_sched_type;

    typedef struct packed {
        rsc_msg_type              kind;
        rsc_sched_type            sched;
        logic [CAUSE_CHARS*8-1:0] cause;
    } rsc_answer_type;

    typedef enum logic [1:0] {
        RSC_IDLE = 2'h0,
        RSC_WAIT = 2'h1
    } rsc_state_type;
endpackage

// file: rtl/rsc_control.sv
// downstream end of the reconfiguration control exchange
// assumes the message layer hands one parsed request per i_req_valid pulse
// and takes one answer per o_ans_valid pulse; policy inputs come from the ensemble side
// Behaviour
// - confirmation messages are sent only by this device, never accepted from upstream
// - device may impose a change unsolicited with a confirmation message
// - pending is set when any confirmation message is sent
// - change request answered by confirmation if accepted, else rejection
// - confirmation name field must name an existing configuration
// - time field eight chars hh:mm:ss, hours to 23, minutes seconds to 59; checked on change requests only, not on imposed schedules
// - frame count six chars uu:lll, upper to 19, lower to 249; checked on change requests only, not on imposed schedules
// - status query answered by confirmation if pending, else rejection
// - withdraw answered by withdraw-accept, or rejection if refused or nothing pending
// - pending cleared when withdraw is accepted and accept is sent
// - withdraw-accept only from device, sent immediately on cancellation
// - rejections only from device, for change, withdraw or query
// - every rejection carries a cause field
// - cause four chars; change refusals use name, instant, pending, resource codes
// - refused query uses no-pending; refused withdraw uses no-pending or too-late
// - at most one pending reconfiguration at a time
// - pending stays until carried out or cancelled; i_srst also clears it; i_change_done is ignored in a request cycle
// - reserved names current and next never accepted in name field
`timescale 1ns/1ps
module rsc_control (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    // requests from upstream
    input  wire logic                   i_req_valid,
    input  rsc_pkg::rsc_req_type        i_req_kind,
    input  rsc_pkg::rsc_sched_type      i_req_sched,
    // ensemble-side policy and events
    input  wire logic                   i_name_known,
    input  wire logic                   i_resource_ok,
    input  wire logic                   i_cancel_late,
    input  wire logic                   i_impose_valid,
    input  rsc_pkg::rsc_sched_type      i_impose_sched,
    input  wire logic                   i_change_done,
    // answers to upstream
    output logic                        o_ans_valid,
    output rsc_pkg::rsc_answer_type     o_ans,
    // schedule state
    output logic                        o_pending,
    output rsc_pkg::rsc_sched_type      o_sched
);
    localparam logic [55:0] RESERVED_CURRENT = 56'h43555252454E54;
    localparam logic [31:0] RESERVED_NEXT    = 32'h4E455854;

    // character pair to value, or 8'hFF when not two digits
    function automatic logic [7:0] two_digits(input logic [15:0] c);
        logic [7:0] hi;
        logic [7:0] lo;
        hi = c[15:8] - rsc_pkg::CHAR_ZERO;
        lo = c[7:0] - rsc_pkg::CHAR_ZERO;
        if (c[15:8] < rsc_pkg::CHAR_ZERO || c[15:8] > rsc_pkg::CHAR_NINE ||
            c[7:0] < rsc_pkg::CHAR_ZERO || c[7:0] > rsc_pkg::CHAR_NINE) begin
            two_digits = 8'hFF;
        end else begin
            two_digits = 8'(hi * 8'h0A + lo);
        end
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= rsc_pkg::CHAR_ZERO) && (c <= rsc_pkg::CHAR_NINE);
    endfunction

    // name is left justified, padded with zero bytes
    function automatic logic name_reserved(input logic [rsc_pkg::NAME_CHARS*8-1:0] n);
        name_reserved = (n == {RESERVED_CURRENT, 72'h0}) ||
                        (n == {RESERVED_NEXT, 96'h0});
    endfunction

    function automatic logic instant_ok(input rsc_pkg::rsc_sched_type s);
        logic [7:0]  hh;
        logic [7:0]  mm;
        logic [7:0]  ss;
        logic [7:0]  uu;
        logic [9:0]  lll;
        logic        fmt;
        hh  = two_digits(s.utc[63:48]);
        mm  = two_digits(s.utc[39:24]);
        ss  = two_digits(s.utc[15:0]);
        uu  = two_digits(s.frame_count_field[47:32]);
        lll = 10'((s.frame_count_field[23:16] - rsc_pkg::CHAR_ZERO) * 7'd100) +
              10'(two_digits(s.frame_count_field[15:0]));
        fmt = (s.utc[47:40] == rsc_pkg::CHAR_COLON) && (s.utc[23:16] == rsc_pkg::CHAR_COLON) &&
              (s.frame_count_field[31:24] == rsc_pkg::CHAR_COLON) &&
              is_digit(s.frame_count_field[23:16]) &&
              two_digits(s.frame_count_field[15:0]) != 8'hFF;
        instant_ok = fmt && hh <= 8'(rsc_pkg::HOUR_MAX) && mm <= 8'(rsc_pkg::MINSEC_MAX) &&
                     ss <= 8'(rsc_pkg::MINSEC_MAX) && uu <= 8'(rsc_pkg::UPPER_MAX) &&
                     lll <= 10'(rsc_pkg::LOWER_MAX);
    endfunction

    rsc_pkg::rsc_state_type   state;
    rsc_pkg::rsc_sched_type   sched;
    rsc_pkg::rsc_answer_type  next_ans;
    logic                     next_ans_valid;
    logic                     next_pending;

    // request decode
    wire logic req_change = i_req_valid && i_req_kind == rsc_pkg::RSC_REQ_CHANGE;
    wire logic req_query  = i_req_valid && i_req_kind == rsc_pkg::RSC_REQ_QUERY;
    wire logic req_cancel = i_req_valid && i_req_kind == rsc_pkg::RSC_REQ_CANCEL;
    wire logic is_pending = state == rsc_pkg::RSC_WAIT;
    // imposed change is honoured only when idle and no request shares the cycle
    wire logic impose_go  = i_impose_valid && !is_pending && !i_req_valid &&
                            i_name_known && !name_reserved(i_impose_sched.name);
    wire logic bad_instant_code_good  = instant_ok(i_req_sched);
    wire logic name_good  = i_name_known && !name_reserved(i_req_sched.name);
    wire logic change_acc = req_change && !is_pending && name_good && bad_instant_code_good &&
                            i_resource_ok;
    wire logic cancel_acc = req_cancel && is_pending && !i_cancel_late;

    // change request cause priority
    wire logic [31:0] change_cause =
        is_pending  ? rsc_pkg::ALREADY_WAITING_CODE :
        !name_good  ? rsc_pkg::NAME_UNKNOWN_CODE :
        !bad_instant_code_good  ? rsc_pkg::BAD_INSTANT_CODE :
                      rsc_pkg::MISSING_RESOURCE_CODE;
    wire logic [31:0] cancel_cause =
        !is_pending ? rsc_pkg::NOTHING_WAITING_CODE : rsc_pkg::TOO_LATE_CODE;

    always_comb begin
        next_ans_valid   = 1'b0;
        next_ans         = '0;
        next_ans.kind    = rsc_pkg::RSC_MSG_REJECT;
        next_ans.sched   = sched;
        next_pending     = is_pending;
        if (i_change_done && is_pending && !i_req_valid) begin
            next_pending = 1'b0;
        end
        if (req_change) begin
            next_ans_valid = 1'b1;
            if (change_acc) begin
                next_ans.kind  = rsc_pkg::RSC_MSG_CONFIRM;
                next_ans.sched = i_req_sched;
                next_pending   = 1'b1;
            end else begin
                next_ans.cause = change_cause;
            end
        end else if (req_query) begin
            next_ans_valid = 1'b1;
            if (is_pending) begin
                next_ans.kind = rsc_pkg::RSC_MSG_CONFIRM;
            end else begin
                next_ans.cause = rsc_pkg::NOTHING_WAITING_CODE;
            end
        end else if (req_cancel) begin
            next_ans_valid = 1'b1;
            if (cancel_acc) begin
                next_ans.kind = rsc_pkg::RSC_MSG_WITHDRAW;
                next_pending  = 1'b0;
            end else begin
                next_ans.cause = cancel_cause;
            end
        end else if (impose_go) begin
            next_ans_valid = 1'b1;
            next_ans.kind  = rsc_pkg::RSC_MSG_CONFIRM;
            next_ans.sched = i_impose_sched;
            next_pending   = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= rsc_pkg::RSC_IDLE;
            sched <= '0;
        end else begin
            state <= next_pending ? rsc_pkg::RSC_WAIT : rsc_pkg::RSC_IDLE;
            if (next_ans_valid && next_ans.kind == rsc_pkg::RSC_MSG_CONFIRM) begin
                sched <= next_ans.sched;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ans_valid <= 1'b0;
            o_ans       <= '0;
            o_pending   <= rsc_pkg::PENDING_RESET;
            o_sched     <= '0;
        end else begin
            o_ans_valid <= next_ans_valid;
            o_ans       <= next_ans;
            o_pending   <= next_pending;
            o_sched     <= next_ans_valid && next_ans.kind == rsc_pkg::RSC_MSG_CONFIRM ?
                           next_ans.sched : sched;
        end
    end

    confirm_sets_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_ans_valid && o_ans.kind == rsc_pkg::RSC_MSG_CONFIRM |-> o_pending)
        else $error("confirmation sent without pending state");
    withdraw_clears_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_ans_valid && o_ans.kind == rsc_pkg::RSC_MSG_WITHDRAW |-> !o_pending)
        else $error("withdraw accept left pending set");
    change_answer_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_change |=> o_ans_valid && o_ans.kind != rsc_pkg::RSC_MSG_WITHDRAW)
        else $error("change request not answered");
    query_answer_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_query |=> o_ans_valid && ((o_ans.kind == rsc_pkg::RSC_MSG_CONFIRM) ==
        $past(is_pending)))
        else $error("query answer disagrees with pending");
    busy_refuse_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_change && is_pending |=> o_ans.cause == rsc_pkg::ALREADY_WAITING_CODE &&
        $stable(sched))
        else $error("change while pending not refused");
    reject_cause_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_ans_valid && o_ans.kind == rsc_pkg::RSC_MSG_REJECT |-> o_ans.cause != '0)
        else $error("rejection without cause");
    cancel_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_cancel && !is_pending |=> o_ans.kind == rsc_pkg::RSC_MSG_REJECT &&
        o_ans.cause == rsc_pkg::NOTHING_WAITING_CODE)
        else $error("withdraw with nothing pending not refused");
    bad_instant_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_change && !is_pending && name_good && !bad_instant_code_good |=>
        o_ans.cause == rsc_pkg::BAD_INSTANT_CODE)
        else $error("malformed instant not refused");
    pending_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        is_pending && !i_change_done && !req_cancel |=> is_pending)
        else $error("pending dropped without cause");
endmodule

// file: verification/rsc_upstream_model.sv
// upstream service provider model: issues change, query and cancel requests
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps
module rsc_upstream_model (
    // requests toward the device
    output logic                   o_req_valid,
    output rsc_pkg::rsc_req_type   o_req_kind,
    output rsc_pkg::rsc_sched_type o_req_sched
);
    initial begin
        o_req_valid = 1'h0;
        o_req_kind  = rsc_pkg::RSC_REQ_QUERY;
        o_req_sched = '0;
    end

    // only change, query and cancel exist on this side, never a confirmation
    task automatic issue(input rsc_pkg::rsc_req_type kind, input rsc_pkg::rsc_sched_type s);
        o_req_valid = 1'h1;
        o_req_kind  = kind;
        o_req_sched = s;
    endtask

    // released lines must not keep showing the last request
    task automatic release_req();
        o_req_valid = 1'h0;
        o_req_kind  = rsc_pkg::rsc_req_type'(~o_req_kind);
        o_req_sched = ~o_req_sched;
    endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the reconfiguration schedule control block
// assumes the upstream model drives requests and the bench plays the ensemble side
`timescale 1ns/1ps
module tb_top;
    localparam rsc_pkg::rsc_req_type CHG = rsc_pkg::RSC_REQ_CHANGE;
    localparam rsc_pkg::rsc_req_type QRY = rsc_pkg::RSC_REQ_QUERY;
    localparam rsc_pkg::rsc_req_type CNL = rsc_pkg::RSC_REQ_CANCEL;
    localparam rsc_pkg::rsc_msg_type CNF = rsc_pkg::RSC_MSG_CONFIRM;
    localparam rsc_pkg::rsc_msg_type WDR = rsc_pkg::RSC_MSG_WITHDRAW;
    localparam rsc_pkg::rsc_msg_type REJ = rsc_pkg::RSC_MSG_REJECT;
    localparam logic [31:0] C_NM = rsc_pkg::NAME_UNKNOWN_CODE;
    localparam logic [31:0] C_IN = rsc_pkg::BAD_INSTANT_CODE;
    localparam logic [31:0] C_PD = rsc_pkg::ALREADY_WAITING_CODE;
    localparam logic [31:0] C_RS = rsc_pkg::MISSING_RESOURCE_CODE;
    localparam logic [31:0] C_NO = rsc_pkg::NOTHING_WAITING_CODE;
    localparam logic [31:0] C_LT = rsc_pkg::TOO_LATE_CODE;

    // policy bits are {name known, resource ok, cancel late}
    typedef struct {
        rsc_pkg::rsc_req_type kind;
        string                nm;
        string                t;
        string                f;
        logic [2:0]           pol;
        rsc_pkg::rsc_msg_type ans;
        logic [31:0]          cause;
        logic                 already_waiting_code;
    } rsc_row_type;

    logic                    clk;
    logic                    srst;
    logic                    req_valid;
    rsc_pkg::rsc_req_type    req_kind;
    rsc_pkg::rsc_sched_type  req_sched;
    logic                    name_known;
    logic                    resource_ok;
    logic                    cancel_late;
    logic                    impose_valid;
    rsc_pkg::rsc_sched_type  impose_sched;
    rsc_pkg::rsc_sched_type  keep;
    logic                    change_done;
    logic                    ans_valid;
    rsc_pkg::rsc_answer_type ans;
    logic                    pending;
    rsc_pkg::rsc_sched_type  sched;
    rsc_row_type             rows [14];
    int                      fail_count = 0;
    int                      checks_done = 0;
    int                      cycles = 0;

    rsc_upstream_model u_rsc_upstream_model (
        .o_req_valid (req_valid),
        .o_req_kind  (req_kind),
        .o_req_sched (req_sched)
    );

    rsc_control u_rsc_control (
        .i_clk          (clk),
        .i_srst         (srst),
        .i_req_valid    (req_valid),
        .i_req_kind     (req_kind),
        .i_req_sched    (req_sched),
        .i_name_known   (name_known),
        .i_resource_ok  (resource_ok),
        .i_cancel_late  (cancel_late),
        .i_impose_valid (impose_valid),
        .i_impose_sched (impose_sched),
        .i_change_done  (change_done),
        .o_ans_valid    (ans_valid),
        .o_ans          (ans),
        .o_pending      (pending),
        .o_sched        (sched)
    );

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    function automatic rsc_pkg::rsc_sched_type sc(input string n, input string t, input string f);
        sc = '0;
        for (int i = 0; i < n.len(); i++) sc.name[(15-i)*8 +: 8] = n[i];
        for (int i = 0; i < t.len(); i++) sc.utc[(7-i)*8 +: 8] = t[i];
        for (int i = 0; i < f.len(); i++) sc.frame_count_field[(5-i)*8 +: 8] = f[i];
    endfunction

    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic expect_ans(input rsc_pkg::rsc_msg_type k, input logic [31:0] c,
                              input rsc_pkg::rsc_sched_type s, input logic p);
        check("answer valid", ans_valid, 1'h1);
        check("answer kind", ans.kind, k);
        if (k == REJ) check("cause", ans.cause, c);
        if (k == CNF) check("schedule", ans.sched, s);
        check("pending", pending, p);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        srst = 1'h1;
        {name_known, resource_ok, cancel_late} = 3'h6;
        impose_valid = 1'h0;
        impose_sched = '0;
        change_done = 1'h0;
        rows = '{
            '{QRY, "", "", "", 3'h6, REJ, C_NO, 1'h0},
            '{CNL, "", "", "", 3'h6, REJ, C_NO, 1'h0},
            '{CHG, "CFGA", "12:00:00", "00:000", 3'h2, REJ, C_NM, 1'h0},
            '{CHG, "CFGA", "24:00:00", "00:000", 3'h6, REJ, C_IN, 1'h0},
            '{CHG, "CFGA", "12:60:00", "00:000", 3'h6, REJ, C_IN, 1'h0},
            '{CHG, "CFGA", "12:00:00", "20:000", 3'h6, REJ, C_IN, 1'h0},
            '{CHG, "CFGA", "12:00:00", "00:250", 3'h6, REJ, C_IN, 1'h0},
            '{CHG, "CFGA", "12:00:00", "00:000", 3'h4, REJ, C_RS, 1'h0},
            '{CHG, "CFGA", "23:59:59", "19:249", 3'h6, CNF, 32'h0, 1'h1},
            '{CHG, "CFGB", "00:00:00", "00:000", 3'h6, REJ, C_PD, 1'h1},
            '{QRY, "CFGA", "23:59:59", "19:249", 3'h6, CNF, 32'h0, 1'h1},
            '{CNL, "", "", "", 3'h7, REJ, C_LT, 1'h1},
            '{CNL, "", "", "", 3'h6, WDR, 32'h0, 1'h0},
            '{QRY, "", "", "", 3'h6, REJ, C_NO, 1'h0}};
        repeat (5) @(posedge clk);
        @(negedge clk);
        srst = 1'h0;
        check("reset pending", pending, 1'h0);
        foreach (rows[i]) begin
            {name_known, resource_ok, cancel_late} = rows[i].pol;
            u_rsc_upstream_model.issue(rows[i].kind, sc(rows[i].nm, rows[i].t, rows[i].f));
            @(negedge clk);
            expect_ans(rows[i].ans, rows[i].cause, sc(rows[i].nm, rows[i].t, rows[i].f),
                       rows[i].already_waiting_code);
        end
        u_rsc_upstream_model.release_req();
        @(negedge clk);
        check("single pulse", ans_valid, 1'h0);
        $display("table rows done");
        {name_known, resource_ok, cancel_late} = 3'h6;
        u_rsc_upstream_model.issue(CHG, sc("NEXT", "12:00:00", "00:000"));
        @(negedge clk);
        u_rsc_upstream_model.release_req();
        expect_ans(REJ, C_NM, '0, 1'h0);
        $display("reserved name test done");
        keep = sc("CFGC", "01:02:00", "03:100");
        impose_sched = keep;
        impose_valid = 1'h1;
        @(negedge clk);
        impose_sched = sc("CFGD", "02:00:00", "00:001");
        expect_ans(CNF, 32'h0, keep, 1'h1);
        @(negedge clk);
        impose_valid = 1'h0;
        check("second impose ignored", ans_valid, 1'h0);
        check("held schedule", sched, keep);
        $display("impose test done");
        change_done = 1'h1;
        @(negedge clk);
        change_done = 1'h0;
        check("done clears pending", pending, 1'h0);
        impose_valid = 1'h1;
        @(negedge clk);
        impose_valid = 1'h0;
        srst = 1'h1;
        @(negedge clk);
        srst = 1'h0;
        check("reset clears pending", pending, 1'h0);
        check("reset clears answer", ans_valid, 1'h0);
        $display("completion and reset test done");
        report_and_stop();
    end
endmodule
